// ==== rtl/gpstg_delay_line.sv ====
`timescale 1ns/1ps
// Delays a level by a programmable number of cycles. Edges closer together
// than the delay are each reproduced, up to the depth of the event memory.
module gpstg_delay_line #(
    parameter int CNT_W = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic level_in,
    input wire logic [CNT_W-1:0] delay,
    output logic level_out
);
    localparam int AW = $clog2(DEPTH);

    logic [CNT_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] fill_q;
    logic [CNT_W-1:0] now_q;
    logic prev_q;
    logic push;
    logic pop;

    // A zero delay bypasses the memory; an event stored then would only
    // come due after a full wrap of the cycle counter.
    assign push = (level_in != prev_q) && (delay != '0) &&
                  (fill_q != (AW+1)'(DEPTH));
    assign pop = (fill_q != '0) && (now_q == mem[rd_q]);

    always_ff @(posedge clk) begin
        if (reset) begin
            now_q <= '0;
            prev_q <= 1'b0;
        end else begin
            now_q <= now_q + 1'b1;
            prev_q <= level_in;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= now_q + delay;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            level_out <= 1'b0;
        end else if (delay == '0) begin
            level_out <= level_in;
        end else if (pop) begin
            level_out <= ~level_out;
        end
    end
endmodule

// ==== rtl/gpstg_pkg.sv ====
// Function
// (RULE1) Each trigger yields one pulse set: plate gate, gate start, gate stop, auxiliary pulse and master sync.
// (RULE2) The photocathode gate rises at the gate start event and falls at the gate stop event.
// (RULE3) The exposure window is high for the whole pulse set and falls about 15 ns after its last pulse; the code holds a one-cycle (50 ns) tail.
// (RULE4) In trigger-per-pulse mode a pulse set starts only on a trigger of its own.
// (RULE5) With the internal source selected, each set starts from the internal trigger.
// (RULE6) With the external source selected, each external trigger starts one set.
// (RULE7) In master-clock operation the internal trigger runs and the master sync output is enabled.
// (RULE8) While waiting for a trigger the sensor flush request stays asserted.
// (RULE9) The operator picks gate width and delay so that the gate covers the light event.
// (RULE10) In swept mode gate delay and width step from start values toward end values per frame.
// (RULE11) In static mode every pulse set uses the same fixed width and delay.
// (RULE12) In gate mode the photocathode is biased on only while the gate pulse is applied.
// (RULE13) The delayed master sync copies the primary one with both edges shifted later.
// (RULE14) The auxiliary pulse has a set width and starts a set delay after primary sync rises.
// (RULE15) Triggers during a running pulse set are ignored until the exposure window falls.
// (RULE16) Gate delay counts clock cycles from the starting trigger to the gate start event.
package gpstg_pkg;

    localparam int CLK_MHZ = 20;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int EXPOSURE_WINDOW_TAIL_NS = 15;
    // Longest time rounds down but never below one cycle.
    localparam int EXPOSURE_WINDOW_TAIL_CYC =
        (EXPOSURE_WINDOW_TAIL_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (EXPOSURE_WINDOW_TAIL_NS / CLK_PERIOD_NS);
    localparam int CNT_W = 24;
    localparam int SYNC_W_RST = 1;
    localparam int AUX_W_RST = 1;
    localparam int GATE_W_RST = 1;
    localparam int DELAY_RST = 0;
    localparam int PERIOD_RST = 20000;

    typedef enum logic [1:0] {
        GPSTG_IDLE,
        GPSTG_RUN,
        GPSTG_TAIL
    } gpstg_state_e;

endpackage

// ==== rtl/gpstg_timing_gen.sv ====
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module gpstg_timing_gen #(
    parameter int CNT_W = gpstg_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CNT_W-1:0] addr,
    input wire logic [CNT_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [CNT_W-1:0] rdata,
    input wire logic ext_trigger,
    output logic plate_gate,
    output logic gate_start,
    output logic gate_stop,
    output logic photocathode_gate,
    output logic first_auxiliary_pulse,
    output logic master_sync_output,
    output logic primary_master_sync,
    output logic delayed_master_sync,
    output logic exposure_window,
    output logic sensor_flush
);
    localparam logic [CNT_W-1:0] A_CTRL = 'h0;
    localparam logic [CNT_W-1:0] A_PERIOD = 'h4;
    localparam logic [CNT_W-1:0] A_DLY_START = 'h8;
    localparam logic [CNT_W-1:0] A_DLY_END = 'hc;
    localparam logic [CNT_W-1:0] A_WID_START = 'h10;
    localparam logic [CNT_W-1:0] A_WID_END = 'h14;
    localparam logic [CNT_W-1:0] A_STEP = 'h18;
    localparam logic [CNT_W-1:0] A_SYNC_W = 'h1c;
    localparam logic [CNT_W-1:0] A_SYNC2_DLY = 'h20;
    localparam logic [CNT_W-1:0] A_AUX_DLY = 'h24;
    localparam logic [CNT_W-1:0] A_AUX_W = 'h28;
    localparam logic [CNT_W-1:0] A_STATUS = 'h2c;
    // Control bits: 0 enable, 1 external source, 2 sync out enable,
    // 3 swept mode, 4 gate mode.
    localparam int B_EN = 0;
    localparam int B_EXT = 1;
    localparam int B_SYNC = 2;
    localparam int B_SWEPT = 3;
    localparam int B_GATE = 4;

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] ctrl_q;
    logic [CNT_W-1:0] period_q, dly_s_q, dly_e_q, wid_s_q, wid_e_q, step_q;
    logic [CNT_W-1:0] sync_w_q, sync2_q, aux_d_q, aux_w_q;
    logic [CNT_W-1:0] cur_dly_q, cur_wid_q;
    logic [CNT_W-1:0] int_cnt_q, set_cnt_q, tail_q, frames_q;
    logic int_trig_q;
    gpstg_pkg::gpstg_state_e state_q;

    function automatic logic [CNT_W-1:0] step_to(
        input logic [CNT_W-1:0] cur,
        input logic [CNT_W-1:0] fin,
        input logic [CNT_W-1:0] stp
    );
        if (cur < fin) begin
            step_to = (fin - cur > stp) ? cur + stp : fin;
        end else begin
            step_to = (cur - fin > stp) ? cur - stp : fin;
        end
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= '0;
            period_q <= CNT_W'(gpstg_pkg::PERIOD_RST);
            dly_s_q <= CNT_W'(gpstg_pkg::DELAY_RST);
            dly_e_q <= CNT_W'(gpstg_pkg::DELAY_RST);
            wid_s_q <= CNT_W'(gpstg_pkg::GATE_W_RST);
            wid_e_q <= CNT_W'(gpstg_pkg::GATE_W_RST);
            step_q <= '0;
            sync_w_q <= CNT_W'(gpstg_pkg::SYNC_W_RST);
            sync2_q <= '0;
            aux_d_q <= '0;
            aux_w_q <= CNT_W'(gpstg_pkg::AUX_W_RST);
        end else if (wr) begin
            case (addr)
                A_CTRL: ctrl_q <= wdata[4:0];
                A_PERIOD: period_q <= wdata;
                A_DLY_START: dly_s_q <= wdata;
                A_DLY_END: dly_e_q <= wdata;
                A_WID_START: wid_s_q <= wdata;
                A_WID_END: wid_e_q <= wdata;
                A_STEP: step_q <= wdata;
                A_SYNC_W: sync_w_q <= wdata;
                A_SYNC2_DLY: sync2_q <= wdata;
                A_AUX_DLY: aux_d_q <= wdata;
                A_AUX_W: aux_w_q <= wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                A_CTRL: rdata <= CNT_W'(ctrl_q);
                A_PERIOD: rdata <= period_q;
                A_DLY_START: rdata <= dly_s_q;
                A_DLY_END: rdata <= dly_e_q;
                A_WID_START: rdata <= wid_s_q;
                A_WID_END: rdata <= wid_e_q;
                A_STEP: rdata <= step_q;
                A_SYNC_W: rdata <= sync_w_q;
                A_SYNC2_DLY: rdata <= sync2_q;
                A_AUX_DLY: rdata <= aux_d_q;
                A_AUX_W: rdata <= aux_w_q;
                A_STATUS: rdata <= {frames_q[CNT_W-3:0],
                                    exposure_window, sensor_flush};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal trigger: one pulse every period_q cycles while enabled with the internal source selected.
    always_ff @(posedge clk) begin
        if (reset || !ctrl_q[B_EN] || ctrl_q[B_EXT]) begin
            int_cnt_q <= '0;
            int_trig_q <= 1'b0;
        end else if (int_cnt_q + 1'b1 >= period_q) begin
            int_cnt_q <= '0;
            int_trig_q <= 1'b1; // [RULE5] [RULE7]
        end else begin
            int_cnt_q <= int_cnt_q + 1'b1;
            int_trig_q <= 1'b0;
        end
    end

    logic trig_sel, trig_take;
    // Source mixing is not supported, so only the selected one is seen.
    assign trig_sel = ctrl_q[B_EXT] ? ext_trigger : int_trig_q; // [RULE6]
    // Triggers seen while a set runs are dropped, not queued.
    assign trig_take = ctrl_q[B_EN] && trig_sel &&
                       state_q == gpstg_pkg::GPSTG_IDLE; // [RULE4] [RULE15]

    logic [CNT_W-1:0] stop_at, aux_end, sync_end, set_end;
    assign stop_at = cur_dly_q + cur_wid_q;
    assign aux_end = aux_d_q + aux_w_q;
    assign sync_end = sync_w_q + sync2_q;
    always_comb begin
        set_end = stop_at;
        if (aux_end > set_end) begin
            set_end = aux_end;
        end
        if (ctrl_q[B_SYNC] && sync_end > set_end) begin
            set_end = sync_end;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= gpstg_pkg::GPSTG_IDLE;
            set_cnt_q <= '0;
            tail_q <= '0;
        end else begin
            case (state_q)
                gpstg_pkg::GPSTG_IDLE: begin
                    set_cnt_q <= '0;
                    if (trig_take) begin
                        state_q <= gpstg_pkg::GPSTG_RUN; // [RULE1]
                    end
                end
                gpstg_pkg::GPSTG_RUN: begin
                    set_cnt_q <= set_cnt_q + 1'b1;
                    // The run includes the last end time itself, so the
                    // closing edges of the set are still produced.
                    if (set_cnt_q >= set_end) begin
                        state_q <= gpstg_pkg::GPSTG_TAIL;
                        tail_q <= '0;
                    end
                end
                gpstg_pkg::GPSTG_TAIL: begin
                    tail_q <= tail_q + 1'b1;
                    if (tail_q + 1'b1 >= CNT_W'(gpstg_pkg::EXPOSURE_WINDOW_TAIL_CYC)) begin
                        state_q <= gpstg_pkg::GPSTG_IDLE; // [RULE3]
                    end
                end
                default: state_q <= gpstg_pkg::GPSTG_IDLE;
            endcase
        end
    end

    // Width and delay step between sets in swept mode, or reload on any cycle while enable is clear, even inside a set.
    always_ff @(posedge clk) begin
        if (reset) begin
            cur_dly_q <= CNT_W'(gpstg_pkg::DELAY_RST);
            cur_wid_q <= CNT_W'(gpstg_pkg::GATE_W_RST);
            frames_q <= '0;
        end else if (!ctrl_q[B_EN]) begin
            cur_dly_q <= dly_s_q; // [RULE11]
            cur_wid_q <= wid_s_q; // [RULE11]
            frames_q <= '0;
        end else if (state_q == gpstg_pkg::GPSTG_TAIL &&
                     tail_q + 1'b1 >= CNT_W'(gpstg_pkg::EXPOSURE_WINDOW_TAIL_CYC)) begin
            frames_q <= frames_q + 1'b1;
            if (ctrl_q[B_SWEPT]) begin
                cur_dly_q <= step_to(cur_dly_q, dly_e_q, step_q); // [RULE10]
                cur_wid_q <= step_to(cur_wid_q, wid_e_q, step_q); // [RULE10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic run;
    logic [CNT_W-1:0] t;
    assign run = state_q == gpstg_pkg::GPSTG_RUN;
    assign t = set_cnt_q;

    logic sync_d;
    logic exp_d;
    // The delay line takes the next sync value, so both copies share one
    // register stage and the programmed delay is exact.
    assign sync_d = run && ctrl_q[B_SYNC] && t < sync_w_q;
    // Flush is the exact complement of the window, so no idle cycle is lost.
    assign exp_d = trig_take ||
                   (state_q != gpstg_pkg::GPSTG_IDLE &&
                    !(state_q == gpstg_pkg::GPSTG_TAIL &&
                      tail_q + 1'b1 >=
                      CNT_W'(gpstg_pkg::EXPOSURE_WINDOW_TAIL_CYC)));

    always_ff @(posedge clk) begin
        if (reset) begin
            gate_start <= 1'b0;
            gate_stop <= 1'b0;
            plate_gate <= 1'b0;
            photocathode_gate <= 1'b0;
            first_auxiliary_pulse <= 1'b0;
            primary_master_sync <= 1'b0;
            exposure_window <= 1'b0;
        end else begin
            gate_start <= run && t == cur_dly_q; // [RULE16]
            gate_stop <= run && t == stop_at;
            plate_gate <= run && t >= cur_dly_q && t < stop_at; // [RULE1]
            // Bias is on only inside the gate when gate mode is chosen.
            photocathode_gate <= run && ctrl_q[B_GATE] &&
                                 t >= cur_dly_q && t < stop_at; // [RULE2] [RULE12]
            first_auxiliary_pulse <= run && t >= aux_d_q &&
                                     t < aux_end; // [RULE14]
            primary_master_sync <= sync_d; // [RULE7]
            exposure_window <= exp_d; // [RULE3]
        end
    end

    assign master_sync_output = primary_master_sync;

    // Flush runs whenever no set is in progress.
    always_ff @(posedge clk) begin
        if (reset) begin
            sensor_flush <= 1'b1;
        end else begin
            sensor_flush <= !exp_d; // [RULE8]
        end
    end

    gpstg_delay_line #(
        .CNT_W(CNT_W),
        .DEPTH(8)
    ) u_sync2 (
        .clk(clk),
        .reset(reset),
        .level_in(sync_d),
        .delay(sync2_q),
        .level_out(delayed_master_sync) // [RULE13]
    );
endmodule

// ==== verification/gpstg_timing_gen_props.sv ====
`timescale 1ns/1ps
module gpstg_timing_gen_props #(
    parameter int CNT_W = gpstg_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CNT_W-1:0] addr,
    input wire logic [CNT_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [CNT_W-1:0] rdata,
    input wire logic plate_gate,
    input wire logic gate_start,
    input wire logic gate_stop,
    input wire logic photocathode_gate,
    input wire logic first_auxiliary_pulse,
    input wire logic master_sync_output,
    input wire logic primary_master_sync,
    input wire logic delayed_master_sync,
    input wire logic exposure_window,
    input wire logic sensor_flush
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [CNT_W-1:0] ctrl_q, wid_q, aux_q, t_q, hi_q;
    logic seen_q;
    logic busy;
    assign busy = plate_gate | first_auxiliary_pulse | primary_master_sync;
    ////////////////////////////////////////////////////////////
    // Shadow copies of the settings are taken from the write port.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= '0;
            wid_q <= CNT_W'(gpstg_pkg::GATE_W_RST);
            aux_q <= CNT_W'(gpstg_pkg::DELAY_RST);
        end else if (wr) begin
            if (addr == 'h0) ctrl_q <= wdata;
            if (addr == 'h10) wid_q <= wdata;
            if (addr == 'h24) aux_q <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        t_q <= exposure_window ? t_q + 1'b1 : '0;
        hi_q <= !exposure_window ? '0 : hi_q + CNT_W'(plate_gate);
        seen_q <= exposure_window & (seen_q | gate_start);
    end
    ////////////////////////////////////////////////////////////
    AST_GATE_OPEN: assert property ($rose(plate_gate) |-> gate_start)
        else $error("plate gate rose without gate start");
    AST_GATE_CLOSE: assert property (gate_stop |-> !plate_gate && $past(plate_gate))
        else $error("gate stop not at plate gate fall");
    AST_PC_BIAS: assert property (ctrl_q[4] |-> photocathode_gate == plate_gate)
        else $error("photocathode biased outside gate");
    AST_SYNC_COPY: assert property (master_sync_output == primary_master_sync)
        else $error("master sync differs from primary");
    AST_EXP_SPAN: assert property (busy |-> exposure_window)
        else $error("pulse outside exposure window");
    AST_EXP_TAIL: assert property ($fell(exposure_window) |-> $past(!busy))
        else $error("exposure fell without tail");
    AST_FLUSH: assert property (sensor_flush == !exposure_window)
        else $error("flush request wrong");
    AST_ONE_START: assert property (gate_start |-> !seen_q)
        else $error("second gate start in one set");
    // Exposure leads the primary sync, which starts the aux delay, by one.
    AST_AUX_DELAY: assert property ($rose(first_auxiliary_pulse) |->
        t_q == aux_q + CNT_W'(1))
        else $error("auxiliary pulse delay wrong");
    AST_STATIC_WIDTH: assert property (gate_stop && !ctrl_q[3] |-> hi_q == wid_q)
        else $error("static gate width wrong");
    AST_RD_QUIET: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data outside read slot");
    cover property ($fell(exposure_window));
    cover property (gate_stop && ctrl_q[3]);
    cover property ($rose(delayed_master_sync));
endmodule
bind gpstg_timing_gen gpstg_timing_gen_props #(.CNT_W(CNT_W)) props_u (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .plate_gate(plate_gate),
    .gate_start(gate_start), .gate_stop(gate_stop),
    .photocathode_gate(photocathode_gate),
    .first_auxiliary_pulse(first_auxiliary_pulse),
    .master_sync_output(master_sync_output),
    .primary_master_sync(primary_master_sync),
    .delayed_master_sync(delayed_master_sync),
    .exposure_window(exposure_window), .sensor_flush(sensor_flush));

// ==== verification/gpstg_trig_src.sv ====
`timescale 1ns/1ps
module gpstg_trig_src (
    input wire logic clk,
    input wire logic fire,
    input wire logic [3:0] hold,
    input wire logic primary_master_sync,
    output logic ext_trigger,
    output logic [7:0] fired
);
    logic [3:0] left_q = '0;
    logic sync_q = 1'b0;
    logic [7:0] cnt_q = '0;
    // A slow source holds its level longer, never past a whole set.
    always @(posedge clk) begin
        if (fire) left_q <= hold;
        else if (left_q != 0) left_q <= left_q - 1'b1;
        sync_q <= primary_master_sync;
        if (primary_master_sync && !sync_q) cnt_q <= cnt_q + 1'b1;
    end
    assign fired = cnt_q;
    assign ext_trigger = left_q != 0;
endmodule

// ==== verification/tb_gpstg_timing_gen.sv ====
`timescale 1ns/1ps
module tb_gpstg_timing_gen;
    localparam int W = gpstg_pkg::CNT_W;
    localparam int SD = 2;
    typedef struct packed {
        logic [W-1:0] dly, wid, len, sd;
    } gpstg_set_s;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
    logic [W-1:0] addr = '0, wdata = '0, rdata, t_q = '0, ds_q, ws_q, sd_q;
    logic [W-1:0] ps_q;
    logic pm_q;
    logic [3:0] hold = 4'h1;
    logic [7:0] fired, f0;
    logic ext_trigger, plate_gate, gate_start, gate_stop, pc_gate, aux;
    logic msync, psync, dsync, exposure_window, sensor_flush, rd_d, dm_q;
    int bad_count = 0, samples_checked = 0;
    gpstg_set_s set_q[$], e;
    logic [W-1:0] rd_q[$];
    gpstg_timing_gen dut_u (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_trigger(ext_trigger), .plate_gate(plate_gate),
        .gate_start(gate_start), .gate_stop(gate_stop),
        .photocathode_gate(pc_gate), .first_auxiliary_pulse(aux),
        .master_sync_output(msync), .primary_master_sync(psync),
        .delayed_master_sync(dsync), .exposure_window(exposure_window),
        .sensor_flush(sensor_flush));
    gpstg_trig_src src_u (.clk(clk), .fire(fire), .hold(hold),
        .primary_master_sync(psync), .ext_trigger(ext_trigger),
        .fired(fired));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wreg(logic [7:0] a, logic [W-1:0] d);
        addr <= W'(a);
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(logic [7:0] a, logic [W-1:0] want);
        rd_q.push_back(want);
        addr <= W'(a);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // Sets of the settings from the delay start value to the aux width.
    task automatic cfg(int ds, de, ws, we, st, sw, ad, aw);
        logic [W-1:0] v [0:8];
        v = '{W'(ds), W'(de), W'(ws), W'(we), W'(st), W'(sw), W'(SD),
              W'(ad), W'(aw)};
        for (int i = 0; i < 9; i++) wreg(8'h08 + 8'(4 * i), v[i]);
    endtask
    function automatic logic [W-1:0] span(int d, w, sw, ad, aw);
        int m;
        m = (d + w > sw + SD) ? d + w : sw + SD;
        if (ad + aw > m) m = ad + aw;
        // One lead cycle before the time base, the end time, then the tail.
        return W'(m + 1 + gpstg_pkg::EXPOSURE_WINDOW_TAIL_CYC);
    endfunction
    task automatic pulse(logic [3:0] h);
        fire <= 1'b1;
        hold <= h;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic drain(int n);
        repeat (n) if (set_q.size() != 0) @(posedge clk);
        check("sets left", W'(set_q.size()), '0);
    endtask
    // A second trigger lands inside the running set and must be ignored.
    task automatic shot(int d, w, sw, ad, aw);
        set_q.push_back('{W'(d), W'(w), span(d, w, sw, ad, aw), W'(SD)});
        pulse(4'(1 + $urandom % 2));
        for (int n = 0; n < 9 && !exposure_window; n++) @(posedge clk);
        pulse(4'h1);
        drain(200);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check("read data", rdata, rd_q.pop_front());
        t_q <= exposure_window ? t_q + 1'b1 : '0;
        dm_q <= dsync;
        pm_q <= psync;
        if (gate_start) ds_q <= t_q;
        if (gate_stop) ws_q <= t_q - ds_q;
        // The delayed copy is timed from the rise of the primary sync.
        if (psync && !pm_q) ps_q <= t_q;
        if (dsync && !dm_q) sd_q <= t_q - ps_q;
        if (!exposure_window && t_q != 0) begin
            if (set_q.size() == 0) check("unexpected set", 1, 0);
            else begin
                e = set_q.pop_front();
                // Exposure opens one cycle before the set's time base.
                check("gate delay", ds_q, e.dly + W'(1));
                check("gate width", ws_q, e.wid);
                check("exposure length", t_q, e.len);
                check("delayed sync", sd_q, e.sd);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("Error watchdog expired");
        conclude();
    end
    initial begin
        int d, w, sw, ad, aw;
        void'($urandom(39362));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check("flush idle", W'(sensor_flush), 1);
        rreg(8'h04, W'(gpstg_pkg::PERIOD_RST));
        rreg(8'h00, '0);
        wreg(8'h30, 'h5a);
        rreg(8'h30, '0);
        pulse(4'h1);
        repeat (20) @(posedge clk);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = 1 + $urandom % 6;
            w = 2 + $urandom % 6;
            sw = 1 + $urandom % 4;
            ad = $urandom % 4;
            aw = 1 + $urandom % 3;
            wreg(8'h00, '0);
            cfg(d, d, w, w, 0, sw, ad, aw);
            wreg(8'h00, 'h17);
            shot(d, w, sw, ad, aw);
        end
        $display("test external static done");
        wreg(8'h00, '0);
        cfg(2, 6, 3, 7, 2, 1, 0, 1);
        wreg(8'h00, 'h1f);
        for (int i = 0; i < 3; i++) shot(2 + 2 * i, 3 + 2 * i, 1, 0, 1);
        $display("test swept done");
        wreg(8'h00, '0);
        cfg(2, 2, 3, 3, 0, 1, 0, 1);
        wreg(8'h04, W'(40));
        f0 = fired;
        repeat (3) set_q.push_back('{W'(2), W'(3), span(2, 3, 1, 0, 1), W'(SD)});
        wreg(8'h00, 'h15);
        drain(300);
        // Status: three frames, window low, flush high.
        rreg(8'h2c, W'((3 << 2) | 1));
        wreg(8'h00, '0);
        check("sync fires", W'(fired - f0), 3);
        $display("test internal done");
        conclude();
    end
endmodule
